// >>> rtl/sbrc_defines.svh
`ifndef SBRC_DEFINES_SVH
`define SBRC_DEFINES_SVH

// ****************************************************************
// timing figures
// ****************************************************************
`define SBRC_CLK_HZ        10000000
`define SBRC_BAUD          9600
`define SBRC_BAUD_DIV      (`SBRC_CLK_HZ / `SBRC_BAUD)
`define SBRC_TRAIN_BYTE    8'h55
`define SBRC_TRAIN_COUNT   2
`define SBRC_GAP_MS        2
`define SBRC_GAP_CYC       ((`SBRC_CLK_HZ / 1000) * `SBRC_GAP_MS)
`define SBRC_RST_MS        10
`define SBRC_RST_CYC       ((`SBRC_CLK_HZ / 1000) * `SBRC_RST_MS)

`endif

// >>> rtl/sbrc_pkg.sv
package sbrc_pkg;

   typedef enum logic [1:0]
   {
      SBRC_BOOT_NORMAL   = 2'h0,
      SBRC_BOOT_RECOVERY = 2'h1
   } sbrc_boot_t;

   typedef enum logic [2:0]
   {
      SBRC_DEV_RESET  = 3'h0,
      SBRC_DEV_SAMPLE = 3'h1,
      SBRC_DEV_RUN    = 3'h3,
      SBRC_DEV_RECOV  = 3'h2,
      SBRC_DEV_LINKUP = 3'h6
   } sbrc_dev_state_t;

   typedef enum logic [2:0]
   {
      SBRC_HOST_IDLE  = 3'h0,
      SBRC_HOST_HOLD  = 3'h1,
      SBRC_HOST_TRAIN = 3'h3,
      SBRC_HOST_GAP   = 3'h2,
      SBRC_HOST_READY = 3'h6
   } sbrc_host_state_t;

endpackage

// >>> rtl/sbrc_if.sv
`timescale 1ns/1ps

interface sbrc_if;
   logic recovery_boot_select_n_o;
   logic recovery_boot_select_n_oe;
   logic sys_reset_n_o;
   logic sys_reset_n_oe;
   logic uart_rx;
   logic uart_tx;
   logic recovery_boot_select_n;
   logic sys_reset_n;

   // pull-ups on both pins: open reads high
   assign recovery_boot_select_n =
      recovery_boot_select_n_oe ? recovery_boot_select_n_o : 1'b1;
   assign sys_reset_n = sys_reset_n_oe ? sys_reset_n_o : 1'b1;

   modport device
   (
      input  recovery_boot_select_n,
      input  sys_reset_n,
      input  uart_rx,
      output uart_tx
   );

   modport host
   (
      output recovery_boot_select_n_o,
      output recovery_boot_select_n_oe,
      output sys_reset_n_o,
      output sys_reset_n_oe,
      output uart_rx,
      input  uart_tx
   );
endinterface

// >>> rtl/sbrc_device.sv
`timescale 1ns/1ps
`include "sbrc_defines.svh"

// Summary of operation
// - low boot-select at start: recovery, no navigation
// - recovery runs from internal LC oscillator
// - recovery ignores configuration pins
// - two 0x55 bytes at 9600 open UART
// - host waits 2 ms after training
// - recovery allows quad flash programming
// - host can hold boot-select low
// - reset pin input-only, pulled up
// - host holds reset low 10 ms
// - system reset clears real-time clock
// - reset only for recovery, not power
module sbrc_device
#(
   parameter int RST_CYC = `SBRC_RST_CYC
)
(
   sbrc_if.device     LINK,
   input  wire logic  MCLK,
   input  wire logic  RST_B,
   input  wire logic  CFG_PINS,
   output logic       NAV_ENABLE,
   output logic       OSC_SEL_LC,
   output logic       CFG_APPLIED,
   output logic       UART_OPEN,
   output logic       FLASH_PROG_EN,
   output logic       RTC_CLEAR,
   output logic       IN_RESET
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [1:0] boot_sync;
   logic [1:0] rst_sync;
   logic [1:0] rx_sync;
   logic [1:0] cfg_sync;
   logic       boot_s;
   logic       rst_s;
   logic       rx_s;
   logic       cfg_s;

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         boot_sync <= 2'h3;
         rst_sync  <= 2'h3;
         rx_sync   <= 2'h3;
         cfg_sync  <= 2'h0;
      end
      else
      begin
         boot_sync <= {boot_sync[0], LINK.recovery_boot_select_n};
         rst_sync  <= {rst_sync[0], LINK.sys_reset_n};
         rx_sync   <= {rx_sync[0], LINK.uart_rx};
         cfg_sync  <= {cfg_sync[0], CFG_PINS};
      end
   end

   assign boot_s = boot_sync[1];
   assign rst_s  = rst_sync[1];
   assign rx_s   = rx_sync[1];
   assign cfg_s  = cfg_sync[1];
   assign LINK.uart_tx = 1'b1;

   // ****************************************************************
   // reset pin detection
   // ****************************************************************
   logic [23:0] low_cnt;
   logic [23:0] next_low_cnt;
   logic        sys_rst;
   logic        next_sys_rst;

   always_comb
   begin
      next_low_cnt = low_cnt;
      next_sys_rst = sys_rst;
      if (rst_s)
      begin
         next_low_cnt = 24'h0;
         next_sys_rst = 1'b0;
      end
      else if (low_cnt >= 24'(RST_CYC - 1))
         next_sys_rst = 1'b1;
      else
         next_low_cnt = low_cnt + 24'h1;
   end

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         low_cnt <= 24'h0;
         sys_rst <= 1'b0;
      end
      else
      begin
         low_cnt <= next_low_cnt;
         sys_rst <= next_sys_rst;
      end
   end

   // ****************************************************************
   // training receiver
   // ****************************************************************
   localparam int DIV = `SBRC_BAUD_DIV;
   logic [10:0] bit_cnt;
   logic [10:0] next_bit_cnt;
   logic [3:0]  bit_idx;
   logic [3:0]  next_bit_idx;
   logic [7:0]  shreg;
   logic [7:0]  next_shreg;
   logic        busy;
   logic        next_busy;
   logic [1:0]  good;
   logic [1:0]  next_good;
   logic        rx_d;
   logic        byte_ok;
   sbrc_pkg::sbrc_dev_state_t state;
   sbrc_pkg::sbrc_dev_state_t next_state;

   always_comb
   begin
      next_bit_cnt = bit_cnt;
      next_bit_idx = bit_idx;
      next_shreg   = shreg;
      next_busy    = busy;
      next_good    = good;
      byte_ok      = 1'b0;
      if (!busy)
      begin
         if (rx_d && !rx_s)
         begin
            next_busy    = 1'b1;
            next_bit_cnt = 11'(DIV / 2);
            next_bit_idx = 4'h0;
         end
      end
      else if (bit_cnt == 11'h0)
      begin
         next_bit_cnt = 11'(DIV - 1);
         next_bit_idx = bit_idx + 4'h1;
         if (bit_idx >= 4'h1 && bit_idx <= 4'h8)
            next_shreg = {rx_s, shreg[7:1]};
         if (bit_idx == 4'h9)
         begin
            next_busy = 1'b0;
            byte_ok = rx_s && (shreg == `SBRC_TRAIN_BYTE);
            if (byte_ok)
               next_good = (good == 2'h3) ? good : good + 2'h1;
            else
               next_good = 2'h0;
         end
      end
      else
         next_bit_cnt = bit_cnt - 11'h1;
      // training only counts while waiting in recovery
      if (state != sbrc_pkg::SBRC_DEV_RECOV)
         next_good = 2'h0;
   end

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         bit_cnt <= 11'h0;
         bit_idx <= 4'h0;
         shreg   <= 8'h0;
         busy    <= 1'b0;
         good    <= 2'h0;
         rx_d    <= 1'b1;
      end
      else
      begin
         bit_cnt <= next_bit_cnt;
         bit_idx <= next_bit_idx;
         shreg   <= next_shreg;
         busy    <= next_busy;
         good    <= next_good;
         rx_d    <= rx_s;
      end
   end

   // ****************************************************************
   // boot state machine
   // ****************************************************************
   logic next_nav;
   logic next_osc;
   logic next_cfg;
   logic next_uart;
   logic next_flash;

   always_comb
   begin
      next_state = state;
      case (state)
         sbrc_pkg::SBRC_DEV_RESET:
            next_state = sbrc_pkg::SBRC_DEV_SAMPLE;
         sbrc_pkg::SBRC_DEV_SAMPLE:
            if (!boot_s)
               next_state = sbrc_pkg::SBRC_DEV_RECOV;
            else
               next_state = sbrc_pkg::SBRC_DEV_RUN;
         sbrc_pkg::SBRC_DEV_RUN:
            next_state = state;
         sbrc_pkg::SBRC_DEV_RECOV:
            if (good >= 2'(`SBRC_TRAIN_COUNT))
               next_state = sbrc_pkg::SBRC_DEV_LINKUP;
         sbrc_pkg::SBRC_DEV_LINKUP:
            next_state = state;
         default:
            next_state = sbrc_pkg::SBRC_DEV_RESET;
      endcase
      if (sys_rst)
         next_state = sbrc_pkg::SBRC_DEV_RESET;
      next_nav  = (next_state == sbrc_pkg::SBRC_DEV_RUN);
      next_cfg  = next_nav && cfg_s;
      next_osc  = (next_state == sbrc_pkg::SBRC_DEV_RECOV) ||
                  (next_state == sbrc_pkg::SBRC_DEV_LINKUP);
      next_uart = (next_state == sbrc_pkg::SBRC_DEV_LINKUP);
      next_flash = next_uart;
   end

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state         <= sbrc_pkg::SBRC_DEV_RESET;
         NAV_ENABLE    <= 1'b0;
         OSC_SEL_LC    <= 1'b0;
         CFG_APPLIED   <= 1'b0;
         UART_OPEN     <= 1'b0;
         FLASH_PROG_EN <= 1'b0;
         RTC_CLEAR     <= 1'b1;
         IN_RESET      <= 1'b1;
      end
      else
      begin
         state         <= next_state;
         NAV_ENABLE    <= next_nav;
         OSC_SEL_LC    <= next_osc;
         CFG_APPLIED   <= next_cfg;
         UART_OPEN     <= next_uart;
         FLASH_PROG_EN <= next_flash;
         RTC_CLEAR     <= sys_rst;
         IN_RESET      <= sys_rst;
      end
   end

endmodule // sbrc_device

// >>> rtl/sbrc_host.sv
`timescale 1ns/1ps
`include "sbrc_defines.svh"

module sbrc_host
#(
   parameter int RST_CYC = `SBRC_RST_CYC,
   parameter int GAP_CYC = `SBRC_GAP_CYC
)
(
   sbrc_if.host       LINK,
   input  wire logic  MCLK,
   input  wire logic  RST_B,
   input  wire logic  START_RECOVERY,
   input  wire logic  START_RESET,
   output logic       BUSY,
   output logic       READY
);

   // ****************************************************************
   // sequencer
   // ****************************************************************
   localparam int DIV = `SBRC_BAUD_DIV;
   sbrc_pkg::sbrc_host_state_t state;
   sbrc_pkg::sbrc_host_state_t next_state;
   logic [23:0] cnt;
   logic [23:0] next_cnt;
   logic [4:0]  bit_idx;
   logic [4:0]  next_bit_idx;
   logic        recov;
   logic        next_recov;
   logic        tx;
   logic        next_tx;
   logic        next_busy;
   logic        next_ready;
   logic [19:0] frame;

   // two frames: start, 0x55 lsb first, stop
   assign frame = {1'b1, `SBRC_TRAIN_BYTE, 1'b0, 1'b1, `SBRC_TRAIN_BYTE, 1'b0};

   always_comb
   begin
      next_state   = state;
      next_cnt     = cnt;
      next_bit_idx = bit_idx;
      next_recov   = recov;
      next_tx      = 1'b1;
      case (state)
         sbrc_pkg::SBRC_HOST_IDLE:
         begin
            next_cnt = 24'h0;
            if (START_RESET || START_RECOVERY)
            begin
               next_recov = START_RECOVERY;
               next_state = sbrc_pkg::SBRC_HOST_HOLD;
            end
         end
         sbrc_pkg::SBRC_HOST_HOLD:
            if (cnt >= 24'(RST_CYC + 8))
            begin
               next_cnt = 24'h0;
               next_bit_idx = 5'h0;
               next_state = recov ? sbrc_pkg::SBRC_HOST_TRAIN
                                  : sbrc_pkg::SBRC_HOST_IDLE;
            end
            else
               next_cnt = cnt + 24'h1;
         sbrc_pkg::SBRC_HOST_TRAIN:
         begin
            next_tx = frame[bit_idx];
            if (cnt >= 24'(DIV - 1))
            begin
               next_cnt = 24'h0;
               next_bit_idx = bit_idx + 5'h1;
               if (bit_idx == 5'd19)
                  next_state = sbrc_pkg::SBRC_HOST_GAP;
            end
            else
               next_cnt = cnt + 24'h1;
         end
         sbrc_pkg::SBRC_HOST_GAP:
            if (cnt >= 24'(GAP_CYC))
               next_state = sbrc_pkg::SBRC_HOST_READY;
            else
               next_cnt = cnt + 24'h1;
         sbrc_pkg::SBRC_HOST_READY:
            if (START_RESET)
            begin
               next_recov = 1'b0;
               next_cnt = 24'h0;
               next_state = sbrc_pkg::SBRC_HOST_HOLD;
            end
         default:
            next_state = sbrc_pkg::SBRC_HOST_IDLE;
      endcase
      next_busy  = (next_state != sbrc_pkg::SBRC_HOST_IDLE) &&
                   (next_state != sbrc_pkg::SBRC_HOST_READY);
      next_ready = (next_state == sbrc_pkg::SBRC_HOST_READY);
   end

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state   <= sbrc_pkg::SBRC_HOST_IDLE;
         cnt     <= 24'h0;
         bit_idx <= 5'h0;
         recov   <= 1'b0;
         tx      <= 1'b1;
         BUSY    <= 1'b0;
         READY   <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         cnt     <= next_cnt;
         bit_idx <= next_bit_idx;
         recov   <= next_recov;
         tx      <= next_tx;
         BUSY    <= next_busy;
         READY   <= next_ready;
      end
   end

   // reset driven only during hold, never as a power switch
   assign LINK.sys_reset_n_o  = 1'b0;
   assign LINK.sys_reset_n_oe = (state == sbrc_pkg::SBRC_HOST_HOLD);
   // boot-select held low through and after reset in recovery
   assign LINK.recovery_boot_select_n_o  = 1'b0;
   assign LINK.recovery_boot_select_n_oe = recov &&
      (state != sbrc_pkg::SBRC_HOST_IDLE);
   assign LINK.uart_rx = tx;

endmodule // sbrc_host

// >>> verif/sbrc_monitor.sv
`timescale 1ns/1ps
`include "sbrc_defines.svh"

// ****************************************************************
// checks on the link pins and device outputs
// ****************************************************************
module sbrc_monitor
#(
   parameter int RST_CYC = `SBRC_RST_CYC
)
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic sys_reset_n,
   input wire logic uart_rx,
   input wire logic CFG_PINS,
   input wire logic NAV_ENABLE,
   input wire logic OSC_SEL_LC,
   input wire logic CFG_APPLIED,
   input wire logic UART_OPEN,
   input wire logic FLASH_PROG_EN,
   input wire logic RTC_CLEAR,
   input wire logic IN_RESET
);
   int low_cnt;
   int next_low_cnt;

   // length of the current low phase of the reset pin
   always_comb next_low_cnt = sys_reset_n ? 0 : low_cnt + 1;

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
         low_cnt <= 0;
      else
         low_cnt <= next_low_cnt;
   end

   default clocking dc @(posedge MCLK);
   endclocking
   default disable iff (!RST_B);

   AST_REC_NO_NAV: assert property (OSC_SEL_LC |-> !NAV_ENABLE)
      else $error("navigation runs in recovery");
   // config pins pass two sync stages and the output register
   AST_CFG_NORMAL: assert property
      (CFG_APPLIED == (NAV_ENABLE && $past(CFG_PINS, 3)))
      else $error("config applied wrongly");
   AST_UART_REC: assert property ($rose(UART_OPEN) |-> OSC_SEL_LC && uart_rx)
      else $error("uart opened outside recovery");
   AST_FLASH_EQ: assert property (FLASH_PROG_EN == UART_OPEN)
      else $error("flash programming mismatch");
   AST_RTC_EQ: assert property (RTC_CLEAR == IN_RESET)
      else $error("rtc clear differs from reset");
   AST_RESET_QUIET: assert property (IN_RESET |-> !NAV_ENABLE && !OSC_SEL_LC && !UART_OPEN)
      else $error("device active in reset");
   AST_RESET_LEN: assert property ($rose(IN_RESET) |-> low_cnt >= RST_CYC)
      else $error("short reset pulse detected");
   AST_NAV_HOLD: assert property ($fell(NAV_ENABLE) |-> IN_RESET)
      else $error("navigation dropped without reset");
   AST_OSC_HOLD: assert property ($fell(OSC_SEL_LC) |-> IN_RESET)
      else $error("oscillator switched without reset");

   COV_UART: cover property ($rose(UART_OPEN));
   COV_PIN_RST: cover property ($rose(IN_RESET));
   COV_NAV: cover property ($rose(NAV_ENABLE));
endmodule // sbrc_monitor

// >>> verif/test_safe_boot_and_reset_control.sv
`timescale 1ns/1ps

// ****************************************************************
// both ends joined, host driven from the bench
// ****************************************************************
module test_safe_boot_and_reset_control;
   localparam int RST_CYC = 20;
   localparam int GAP_CYC = 50;

   logic mclk = 1'b0;
   logic rst_b;
   logic cfg_pins;
   logic start_recovery;
   logic start_reset;
   logic nav_enable;
   logic osc_sel_lc;
   logic cfg_applied;
   logic uart_open;
   logic flash_prog_en;
   logic rtc_clear;
   logic in_reset;
   logic busy;
   logic ready;
   int   error_cnt = 0;
   int   compares = 0;

   sbrc_if link();

   sbrc_device #(.RST_CYC(RST_CYC)) i_sbrc_device
   (
      .LINK(link.device), .MCLK(mclk), .RST_B(rst_b), .CFG_PINS(cfg_pins),
      .NAV_ENABLE(nav_enable), .OSC_SEL_LC(osc_sel_lc),
      .CFG_APPLIED(cfg_applied), .UART_OPEN(uart_open),
      .FLASH_PROG_EN(flash_prog_en), .RTC_CLEAR(rtc_clear),
      .IN_RESET(in_reset)
   );

   sbrc_host #(.RST_CYC(RST_CYC), .GAP_CYC(GAP_CYC)) i_sbrc_host
   (
      .LINK(link.host), .MCLK(mclk), .RST_B(rst_b),
      .START_RECOVERY(start_recovery), .START_RESET(start_reset),
      .BUSY(busy), .READY(ready)
   );

   sbrc_monitor #(.RST_CYC(RST_CYC)) i_sbrc_monitor
   (
      .MCLK(mclk), .RST_B(rst_b), .sys_reset_n(link.sys_reset_n),
      .uart_rx(link.uart_rx), .CFG_PINS(cfg_pins),
      .NAV_ENABLE(nav_enable), .OSC_SEL_LC(osc_sel_lc),
      .CFG_APPLIED(cfg_applied), .UART_OPEN(uart_open),
      .FLASH_PROG_EN(flash_prog_en), .RTC_CLEAR(rtc_clear),
      .IN_RESET(in_reset)
   );

   always #50 mclk = ~mclk;

   task test_done;
      $display("counts: compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s exp %b got %b", nm, exp, got);
      end
   endtask

   function logic cond(input int sel);
      case (sel)
         0: cond = ready;
         1: cond = in_reset;
         2: cond = !busy;
         default: cond = uart_open;
      endcase
   endfunction

   task wait_on(input int sel, input int lim);
      int n;
      n = 0;
      while (cond(sel) !== 1'b1 && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
      if (n >= lim)
      begin
         error_cnt++;
         $display("BAD wait %0d exp 1 got 0", sel);
         test_done();
      end
   endtask

   // released boot-select, config pins low then high
   task test_normal;
      repeat (10) @(negedge mclk);
      chk("nav", 1'b1, nav_enable);
      chk("osc", 1'b0, osc_sel_lc);
      chk("cfg_lo", 1'b0, cfg_applied);
      chk("pin_hi", 1'b1, link.sys_reset_n);
      cfg_pins = 1'b1;
      repeat (3) @(negedge mclk);
      chk("cfg_hi", 1'b1, cfg_applied);
      chk("uart", 1'b0, uart_open);
      $display("test normal done");
   endtask

   // recovery boot, a reset request while busy is ignored
   task test_recovery;
      start_recovery = 1'b1;
      @(negedge mclk);
      start_recovery = 1'b0;
      repeat (5) @(negedge mclk);
      start_reset = 1'b1;
      @(negedge mclk);
      start_reset = 1'b0;
      wait_on(3, 40000);
      repeat (GAP_CYC) @(negedge mclk);
      chk("early_ready", 1'b0, ready);
      wait_on(0, 2000);
      chk("nav", 1'b0, nav_enable);
      chk("osc", 1'b1, osc_sel_lc);
      chk("cfg", 1'b0, cfg_applied);
      chk("uart", 1'b1, uart_open);
      chk("flash", 1'b1, flash_prog_en);
      chk("rtc", 1'b0, rtc_clear);
      $display("test recovery done");
   endtask

   // pin reset from ready, back to normal boot
   task test_pin_reset;
      start_reset = 1'b1;
      @(negedge mclk);
      start_reset = 1'b0;
      wait_on(1, RST_CYC + 20);
      chk("rtc", 1'b1, rtc_clear);
      chk("osc", 1'b0, osc_sel_lc);
      chk("uart", 1'b0, uart_open);
      wait_on(2, 100);
      repeat (10) @(negedge mclk);
      chk("rtc_off", 1'b0, rtc_clear);
      chk("nav", 1'b1, nav_enable);
      chk("cfg", 1'b1, cfg_applied);
      chk("ready", 1'b0, ready);
      $display("test pin reset done");
   endtask

   initial
   begin
      rst_b = 1'b0;
      cfg_pins = 1'b0;
      start_recovery = 1'b0;
      start_reset = 1'b0;
      repeat (10) @(negedge mclk);
      chk("rst_rtc", 1'b1, rtc_clear);
      rst_b = 1'b1;
      test_normal();
      test_recovery();
      test_pin_reset();
      test_done();
   end
endmodule // test_safe_boot_and_reset_control
